/* File: hw/lfc_frame_ctrl.sv */
`default_nettype none
module lfc_frame_ctrl
    import lfc_pkg::*;
#(
    parameter int SUB_DIV_CL0 = DEF_SUB_DIV_CL0,
    parameter int DIV_CL1     = DEF_DIV_CL1,
    parameter int DIV_CL2     = DEF_DIV_CL2,
    parameter int DIV_CL3_OSC = DEF_DIV_CL3_OSC,
    parameter int SUB_DIV_CL3 = DEF_SUB_DIV_CL3,
    parameter int CNT_W       = DEF_CNT_W
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_N,
    // AXI4-Lite write
    input  wire logic [AXI_AW-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic      [1:0]        BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    // AXI4-Lite read
    input  wire logic [AXI_AW-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic      [31:0]       RDATA,
    output logic      [1:0]        RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    // Clock sources
    input  wire logic              SUB_CLK_IN,
    input  wire logic              TIMER_A_MODE_BIT3,
    // Frame timing
    output logic                   FRAME_PULSE,
    output logic                   FRAME_TOGGLE,
    output logic      [1:0]        LCD_DUTY,
    // LCD control
    output logic                   DISPLAY_ENABLE,
    output logic                   LCD_POWER_SWITCH,
    output logic                   WATCH_DISPLAY,
    output logic                   RESISTOR_DISCONNECT,
    // Shared port/segment pins
    input  wire logic [7:0]        SEG_DRIVE,
    input  wire logic [7:0]        PORT_OUT,
    input  wire logic [7:0]        PORT_OE,
    output logic      [7:0]        PORT_IN,
    input  wire logic [7:0]        PIN_IN,
    output logic      [7:0]        PIN_OUT,
    output logic      [7:0]        PIN_OE
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [7:0]        awaddr_reg;
    logic [3:0]        wdata_reg;
    logic              wstrb0_reg;
    logic [3:0]        lcd_ctrl_reg;
    logic [3:0]        clock_duty_reg;
    logic [3:0]        seg_sel_reg;
    logic [6:0]        status_w;
    wire logic         aw_take    = AWVALID && AWREADY;
    wire logic         w_take     = WVALID && WREADY;
    wire logic         ar_take    = ARVALID && ARREADY;
    wire logic         do_write   = aw_full_reg && w_full_reg && !BVALID;
    wire logic [7:0]   wr_word    = awaddr_reg & ADDR_WORD_MASK;
    wire logic [7:0]   rd_word    = ARADDR & ADDR_WORD_MASK;
    wire logic         wr_lcr     = wr_word == ADDR_LCD_CONTROL;
    wire logic         wr_cds     = wr_word == ADDR_CLOCK_DUTY;
    wire logic         wr_seg     = wr_word == ADDR_SEG_SELECT;
    wire logic         wr_hit     = wr_lcr || wr_cds || wr_seg;
    wire logic         wr_en      = do_write && wstrb0_reg;
    wire logic         rd_wo      = rd_word == ADDR_LCD_CONTROL ||
                                    rd_word == ADDR_CLOCK_DUTY ||
                                    rd_word == ADDR_SEG_SELECT;
    wire logic         rd_st      = rd_word == ADDR_STATUS;
    wire logic         aw_full_next = (aw_full_reg || aw_take) && !do_write;
    wire logic         w_full_next  = (w_full_reg || w_take) && !do_write;
    wire logic         bvalid_next  = do_write || (BVALID && !BREADY);
    wire logic         rvalid_next  = ar_take || (RVALID && !RREADY);
    // Write-only registers read as zero; status reflects the applied setup
    wire logic [31:0]  rdata_next   = rd_st ? {25'h0, status_w} : 32'h0;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            AWREADY     <= 1'b1;
            WREADY      <= 1'b1;
            BVALID      <= 1'b0;
            BRESP       <= RESP_OKAY;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            AWREADY     <= !aw_full_next && !bvalid_next;
            WREADY      <= !w_full_next && !bvalid_next;
            BVALID      <= bvalid_next;
            if (do_write)
                BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            awaddr_reg <= 8'h00;
            wdata_reg  <= 4'h0;
            wstrb0_reg <= 1'b0;
        end
        else
        begin
            if (aw_take)
                awaddr_reg <= AWADDR;
            if (w_take)
            begin
                wdata_reg  <= WDATA[3:0];
                wstrb0_reg <= WSTRB[0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0;
            RRESP   <= RESP_OKAY;
        end
        else
        begin
            ARREADY <= !rvalid_next;
            RVALID  <= rvalid_next;
            if (ar_take)
            begin
                RDATA <= rdata_next;
                RRESP <= (rd_wo || rd_st) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            lcd_ctrl_reg   <= LCD_CONTROL_RST;
            clock_duty_reg <= CLOCK_DUTY_RST;
            seg_sel_reg    <= SEG_SELECT_RST;
        end
        else if (wr_en)
        begin
            if (wr_lcr)
                lcd_ctrl_reg <= wdata_reg;
            if (wr_cds)
                clock_duty_reg <= wdata_reg;
            if (wr_seg)
                seg_sel_reg <= wdata_reg & 4'h6;
        end
    end

    assign DISPLAY_ENABLE      = lcd_ctrl_reg[LCR_BLANK_BIT];
    assign LCD_POWER_SWITCH    = lcd_ctrl_reg[LCR_POWER_BIT];
    assign WATCH_DISPLAY       = lcd_ctrl_reg[LCR_WATCH_BIT];
    assign RESISTOR_DISCONNECT = lcd_ctrl_reg[LCR_RES_BIT];

    // ----------------------------------------------------------------
    // Frame clock selection
    // ----------------------------------------------------------------
    logic              sub_sync;
    logic              sub_prev_reg;
    logic [7:0]        pin_sync;
    lfc_src_t          src_app_reg;
    lfc_duty_t         duty_app_reg;
    logic              timer_a_mode_bit3_app_reg;
    logic [CNT_W-1:0]  limit_w;
    logic [CNT_W-1:0]  count_w;
    logic              tick_w;

    lfc_sync2 #(.W(1)) u_sub_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .d     (SUB_CLK_IN),
        .q     (sub_sync)
    );

    lfc_sync2 #(.W(8)) u_pin_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .d     (PIN_IN),
        .q     (pin_sync)
    );

    wire logic         sub_rise = sub_sync && !sub_prev_reg;
    wire logic         use_sub  = (src_app_reg == SRC_SUB64) ||
                                  (src_app_reg == SRC_TIMER && timer_a_mode_bit3_app_reg);
    wire logic         adv_w    = use_sub ? sub_rise : 1'b1;
    wire logic [31:0]  den_w    = {28'h0, DUTY_DEN_BASE - {2'b00, duty_app_reg}};
    wire logic [31:0]  base_w   = (src_app_reg == SRC_SUB64) ? 32'(SUB_DIV_CL0) :
                                  (src_app_reg == SRC_OSC1K) ? 32'(DIV_CL1) :
                                  (src_app_reg == SRC_OSC8K) ? 32'(DIV_CL2) :
                                  timer_a_mode_bit3_app_reg ? 32'(SUB_DIV_CL3) : 32'(DIV_CL3_OSC);
    wire logic [31:0]  prod_w   = base_w * den_w;
    wire logic         pending  = clock_duty_reg != {src_app_reg, duty_app_reg} ||
                                  TIMER_A_MODE_BIT3 != timer_a_mode_bit3_app_reg;

    assign limit_w = prod_w[CNT_W-1:0] - CNT_W'(1);

    lfc_prescaler #(.W(CNT_W)) u_prescaler (
        .clk   (CLK),
        .rst_n (RST_N),
        .adv   (adv_w),
        .limit (limit_w),
        .count (count_w),
        .tick  (tick_w)
    );

    // A change taken mid-frame would give one short or long frame; hold it off
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            src_app_reg  <= SRC_SUB64;
            duty_app_reg <= DUTY_QUARTER;
            timer_a_mode_bit3_app_reg <= 1'b0;
        end
        else if (tick_w)
        begin
            src_app_reg  <= lfc_src_t'(clock_duty_reg[CDS_SRC_LSB +: 2]);
            duty_app_reg <= lfc_duty_t'(clock_duty_reg[CDS_DUTY_LSB +: 2]);
            timer_a_mode_bit3_app_reg <= TIMER_A_MODE_BIT3;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sub_prev_reg <= 1'b0;
            FRAME_PULSE  <= 1'b0;
            FRAME_TOGGLE <= 1'b0;
        end
        else
        begin
            sub_prev_reg <= sub_sync;
            FRAME_PULSE  <= tick_w;
            FRAME_TOGGLE <= FRAME_TOGGLE ^ tick_w;
        end
    end

    assign LCD_DUTY = duty_app_reg;

    assign status_w[ST_DUTY_LSB +: 2] = duty_app_reg;
    assign status_w[ST_SRC_LSB +: 2]  = src_app_reg;
    assign status_w[ST_TIMER_A_MODE_BIT3_BIT]      = timer_a_mode_bit3_app_reg;
    assign status_w[ST_PEND_BIT]      = pending;
    assign status_w[ST_TOGGLE_BIT]    = FRAME_TOGGLE;

    // ----------------------------------------------------------------
    // Port / segment pin sharing
    // ----------------------------------------------------------------
    wire logic [7:0]   seg_mode = {{4{seg_sel_reg[SEG_P7_BIT]}},
                                   {4{seg_sel_reg[SEG_P6_BIT]}}};
    wire logic [7:0]   out_next = (seg_mode & SEG_DRIVE) | (~seg_mode & PORT_OUT);
    wire logic [7:0]   oe_next  = seg_mode | PORT_OE;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PIN_OUT <= 8'h00;
            PIN_OE  <= 8'h00;
        end
        else
        begin
            PIN_OUT <= out_next;
            PIN_OE  <= oe_next;
        end
    end

    assign PORT_IN = pin_sync;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_frame_at_limit: assert property (tick_w |-> count_w >= limit_w ##1 FRAME_PULSE)
        else $error("frame pulse not tied to prescaler wrap");
    a_timer_src_pick: assert property (src_app_reg == SRC_TIMER |-> use_sub == timer_a_mode_bit3_app_reg)
        else $error("timer source ignores timer mode bit 3");
    a_timer_osc_div: assert property (src_app_reg == SRC_TIMER && !timer_a_mode_bit3_app_reg |->
            32'(limit_w) == 32'(DIV_CL3_OSC) * den_w - 32'd1 && adv_w)
        else $error("timer source oscillator ratio wrong");
    a_timer_sub_div: assert property (src_app_reg == SRC_TIMER && timer_a_mode_bit3_app_reg |->
            32'(limit_w) == 32'(SUB_DIV_CL3) * den_w - 32'd1 && adv_w == sub_rise)
        else $error("timer source sub-clock ratio wrong");
    a_seg_reg_write: assert property (wr_en && wr_seg |=>
            seg_sel_reg == ($past(wdata_reg) & 4'h6))
        else $error("segment select write not stored");
    a_seg_pins_route: assert property (seg_sel_reg[SEG_P6_BIT] && !$changed(seg_sel_reg) |=>
            PIN_OE[3:0] == 4'hf && PIN_OUT[3:0] == $past(SEG_DRIVE[3:0]))
        else $error("group six not driven as segments");
    a_port_pins_keep: assert property (!seg_sel_reg[SEG_P7_BIT] && !$changed(seg_sel_reg) |=>
            PIN_OE[7:4] == $past(PORT_OE[7:4]))
        else $error("group seven not left as port");
    a_osc_div_sel: assert property (src_app_reg == SRC_OSC1K |->
            32'(limit_w) == 32'(DIV_CL1) * den_w - 32'd1 && !use_sub)
        else $error("oscillator divide by 1024 wrong");
    a_power_switch: assert property (wr_en && wr_lcr |=>
            LCD_POWER_SWITCH == $past(wdata_reg[LCR_POWER_BIT]))
        else $error("power switch does not follow its bit");
    a_cfg_at_frame: assert property ($changed({src_app_reg, duty_app_reg, timer_a_mode_bit3_app_reg}) |->
            $past(tick_w))
        else $error("selection applied off a frame boundary");

    c_sub_frame:  cover property (use_sub && tick_w);
    c_timer_osc:  cover property (src_app_reg == SRC_TIMER && !timer_a_mode_bit3_app_reg && tick_w);
    c_seg_mode:   cover property (seg_sel_reg == 4'h6 ##1 PIN_OE == 8'hff);
    c_bad_access: cover property (BVALID && BRESP == RESP_SLVERR);

endmodule
`default_nettype wire

/* File: hw/lfc_pkg.sv */
`default_nettype none
package lfc_pkg;

    // ----------------------------------------------------------------
    // Register map: printed offsets are indexes, byte address = 4 x index
    // ----------------------------------------------------------------
    localparam int          AXI_AW            = 8;
    localparam logic [5:0]  IDX_LCD_CONTROL   = 6'h1b;
    localparam logic [5:0]  IDX_CLOCK_DUTY    = 6'h1c;
    localparam logic [5:0]  IDX_SEG_SELECT    = 6'h1f;
    localparam logic [5:0]  IDX_STATUS        = 6'h20;
    localparam logic [7:0]  ADDR_LCD_CONTROL  = {IDX_LCD_CONTROL, 2'b00};
    localparam logic [7:0]  ADDR_CLOCK_DUTY   = {IDX_CLOCK_DUTY, 2'b00};
    localparam logic [7:0]  ADDR_SEG_SELECT   = {IDX_SEG_SELECT, 2'b00};
    localparam logic [7:0]  ADDR_STATUS       = {IDX_STATUS, 2'b00};
    localparam logic [7:0]  ADDR_WORD_MASK    = 8'hfc;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  LCD_CONTROL_RST   = 4'h0;
    localparam logic [3:0]  CLOCK_DUTY_RST    = 4'h0;
    localparam logic [3:0]  SEG_SELECT_RST    = 4'h0;
    localparam int          LCR_BLANK_BIT     = 0;
    localparam int          LCR_POWER_BIT     = 1;
    localparam int          LCR_WATCH_BIT     = 2;
    localparam int          LCR_RES_BIT       = 3;
    localparam int          CDS_DUTY_LSB      = 0;
    localparam int          CDS_SRC_LSB       = 2;
    localparam int          SEG_P6_BIT        = 1;
    localparam int          SEG_P7_BIT        = 2;
    localparam int          ST_DUTY_LSB       = 0;
    localparam int          ST_SRC_LSB        = 2;
    localparam int          ST_TIMER_A_MODE_BIT3_BIT       = 4;
    localparam int          ST_PEND_BIT       = 5;
    localparam int          ST_TOGGLE_BIT     = 6;

    typedef enum logic [1:0] {
        SRC_SUB64   = 2'h0,
        SRC_OSC1K   = 2'h1,
        SRC_OSC8K   = 2'h2,
        SRC_TIMER   = 2'h3
    } lfc_src_t;

    typedef enum logic [1:0] {
        DUTY_QUARTER = 2'h0,
        DUTY_THIRD   = 2'h1,
        DUTY_HALF    = 2'h2,
        DUTY_STATIC  = 2'h3
    } lfc_duty_t;

    // ----------------------------------------------------------------
    // Division ratios (frame period per unit of duty denominator)
    // ----------------------------------------------------------------
    localparam int          DEF_SUB_DIV_CL0   = 64;
    localparam int          DEF_DIV_CL1       = 1024;
    localparam int          DEF_DIV_CL2       = 8192;
    localparam int          DEF_DIV_CL3_OSC   = 16384;
    localparam int          DEF_SUB_DIV_CL3   = 512;
    localparam int          DEF_CNT_W         = 17;
    localparam logic [3:0]  DUTY_DEN_BASE     = 4'h4;

    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

endpackage
`default_nettype wire

/* File: hw/lfc_sync2.sv */
`default_nettype none
module lfc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: hw/lfc_prescaler.sv */
`default_nettype none
module lfc_prescaler #(
    parameter int W = 17
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Count control
    input  wire logic         adv,
    input  wire logic [W-1:0] limit,
    // State
    output logic      [W-1:0] count,
    output logic              tick
);
    // Wrap on >= so a shrinking limit never lets the count run away
    assign tick = adv && (count >= limit);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else if (tick)
            count <= '0;
        else if (adv)
            count <= count + W'(1);
    end
endmodule
`default_nettype wire

/* File: dv/lfc_panel_model.sv */
`default_nettype none
module lfc_panel_model (
    // Clock
    input  wire logic       clk,
    // Pins from the device
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // Level seen back on the shared pins
    output logic      [7:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] last_reg = 8'h00;

    // Undriven electrodes have no pull: show a changing level, never a held one
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ~last_reg);

    always_ff @(posedge clk)
    begin
        last_reg <= pin_lvl;
    end
endmodule
`default_nettype wire

/* File: dv/lfc_frame_ctrl_tb_top.sv */
`default_nettype none
module lfc_frame_ctrl_tb_top
    import lfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Shortened dividers so every source ends frames quickly
    // ----------------------------------------------------------------
    localparam int P_SUB0  = 4;
    localparam int P_DIV1  = 16;
    localparam int P_DIV2  = 32;
    localparam int P_DIV3  = 64;
    localparam int P_SUB3  = 8;
    localparam int SUB_PER = 8;
    localparam int LIM     = 2000;

    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic [7:0]  awaddr   = 8'h00;
    logic [7:0]  araddr   = 8'h00;
    logic [31:0] wdata    = 32'h0;
    logic        awvalid  = 1'b0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic        sub_clk  = 1'b0;
    logic [1:0]  sub_cnt  = 2'h0;
    logic        tmr3     = 1'b0;
    logic [7:0]  seg_drive = 8'h00;
    logic [7:0]  port_out = 8'h00;
    logic [7:0]  port_oe  = 8'h00;
    logic        chk      = 1'b0;
    logic [31:0] rng      = 32'h000039bf;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, lcd_duty;
    logic [31:0] rdata;
    logic        frame_pulse, frame_toggle, disp_en, pwr_sw, watch_disp, res_disc;
    logic [7:0]  pin_lvl, pin_out, pin_oe, port_in;
    logic [63:0] bexp_q[$];
    logic [1:0]  dexp_q[$];
    logic [63:0] rexp_q[$];
    logic [63:0] pexp_q[$];
    int          per_q[$];
    int          gap = 0;
    int          pulses = 0;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    logic [4:0]  cfg_tab [6] = '{5'b01_00_0, 5'b10_11_0, 5'b11_10_0,
                                 5'b11_01_1, 5'b00_11_1, 5'b00_00_0};

    lfc_frame_ctrl #(
        .SUB_DIV_CL0(P_SUB0), .DIV_CL1(P_DIV1), .DIV_CL2(P_DIV2),
        .DIV_CL3_OSC(P_DIV3), .SUB_DIV_CL3(P_SUB3), .CNT_W(17)
    ) dut (
        .CLK(clk), .RST_N(rst_n),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .SUB_CLK_IN(sub_clk), .TIMER_A_MODE_BIT3(tmr3),
        .FRAME_PULSE(frame_pulse), .FRAME_TOGGLE(frame_toggle), .LCD_DUTY(lcd_duty),
        .DISPLAY_ENABLE(disp_en), .LCD_POWER_SWITCH(pwr_sw),
        .WATCH_DISPLAY(watch_disp), .RESISTOR_DISCONNECT(res_disc),
        .SEG_DRIVE(seg_drive), .PORT_OUT(port_out), .PORT_OE(port_oe), .PORT_IN(port_in),
        .PIN_IN(pin_lvl), .PIN_OUT(pin_out), .PIN_OE(pin_oe)
    );

    lfc_panel_model panel (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl)
    );

    always #2.5 clk = ~clk;

    // Sub-clock stand-in on a steady phase, so synchroniser delay stays constant
    always @(posedge clk)
    begin
        sub_cnt <= sub_cnt + 2'h1;
        if (sub_cnt == 2'h3)
            sub_clk <= ~sub_clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic int exp_period(logic [1:0] s, logic [1:0] d, logic t);
        int den;
        den = 4 - int'(d);
        case (s)
            2'h0:    return P_SUB0 * den * SUB_PER;
            2'h1:    return P_DIV1 * den;
            2'h2:    return P_DIV2 * den;
            default: return t ? P_SUB3 * den * SUB_PER : P_DIV3 * den;
        endcase
    endfunction

    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= LIM)
        begin
            n_mismatch++;
            $display("ERROR %0t: wait ran out", $time);
            give_verdict();
        end
    endtask

    task automatic cmp_val(input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t: value exp %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_period(input int e, input int g);
        samples_checked++;
        if (g != e)
        begin
            n_mismatch++;
            $display("ERROR %0t: frame period exp %0d got %0d", $time, e, g);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        bexp_q.push_back({62'h0, er});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awready)
                aw_ok = 1'b1;
            if (wready)
                w_ok = 1'b1;
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end
        while (!(aw_ok && w_ok) && n < LIM);
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!bvalid && n < LIM);
        bready <= 1'b0;
        tmo(n);
        @(posedge clk);
    endtask

    task automatic bus_read(input logic [7:0] a, input logic [33:0] e);
        int n;
        n = 0;
        rexp_q.push_back({30'h0, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!arready && n < LIM);
        arvalid <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!rvalid && n < LIM);
        rready <= 1'b0;
        tmo(n);
        @(posedge clk);
    endtask

    task automatic wait_pulse();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!frame_pulse && n < LIM);
        tmo(n);
    endtask

    task automatic pin_round();
        logic [31:0] r;
        logic [7:0]  g;
        logic [7:0]  o;
        r = xs();
        seg_drive <= r[7:0];
        port_out <= r[15:8];
        port_oe <= r[23:16];
        bus_write(ADDR_SEG_SELECT, {28'h0, r[27:24]}, RESP_OKAY);
        bus_write(ADDR_LCD_CONTROL, {28'h0, r[31:28]}, RESP_OKAY);
        g = {{4{r[24 + SEG_P7_BIT]}}, {4{r[24 + SEG_P6_BIT]}}};
        o = (g & r[7:0]) | (~g & r[15:8]);
        // Duty stays at its reset value until the frame scenarios run
        pexp_q.push_back({34'h0, 2'h0, r[31:28], g | r[23:16], o, o & (g | r[23:16])});
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Result watcher: oldest note against each result as it appears
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        gap = gap + 1;
        if (bvalid && bready)
            cmp_val(bexp_q.pop_front(), {62'h0, bresp});
        if (rvalid && rready)
            cmp_val(rexp_q.pop_front(), {30'h0, rresp, rdata});
        if (chk)
            cmp_val(pexp_q.pop_front(), {34'h0, lcd_duty, res_disc, watch_disp, pwr_sw,
                                         disp_en, pin_oe, pin_out, port_in & pin_oe});
        if (frame_pulse)
        begin
            pulses = pulses + 1;
            cmp_val({63'h0, pulses[0]}, {63'h0, frame_toggle});
            if (per_q.size() > 0)
            begin
                cmp_period(per_q.pop_front(), gap);
                cmp_val({62'h0, dexp_q.pop_front()}, {62'h0, lcd_duty});
            end
            gap = 0;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [4:0] c;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus_read(ADDR_STATUS, {RESP_OKAY, 32'h0});
        bus_read(ADDR_SEG_SELECT, {RESP_OKAY, 32'h0});
        bus_read(8'h04, {RESP_SLVERR, 32'h0});
        bus_write(8'h04, 32'h0000000f, RESP_SLVERR);
        // Pins must still be plain ports before any select write
        pexp_q.push_back({34'h0, 2'h0, 4'h0, port_oe, port_out, port_out & port_oe});
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
        // Power switch opened before anything touches the drive supply
        bus_write(ADDR_LCD_CONTROL, 32'h0, RESP_OKAY);
        repeat (8) pin_round();
        for (int i = 0; i < 6; i++)
        begin
            c = cfg_tab[i];
            tmr3 <= c[0];
            bus_write(ADDR_CLOCK_DUTY, {28'h0, c[4:1]}, RESP_OKAY);
            // First frame may still be the old setup when the write hits a wrap
            wait_pulse();
            wait_pulse();
            @(posedge clk);
            per_q.push_back(exp_period(c[4:3], c[2:1], c[0]));
            dexp_q.push_back(c[2:1]);
            // Status packs timer bit above source and duty
            bus_read(ADDR_STATUS, {RESP_OKAY, 25'h0, pulses[0], 1'b0, c[0], c[4:1]});
            wait_pulse();
            @(posedge clk);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
